/* File: hw/tsw_top.v */
/*
  time-slot interchange switch front end: eight serial streams in and
  out, frame polarity detection, 256 x 256 switching through flip-flop
  memories, frame evaluation measurement and a parallel host port.
  assumes the serial clock, frame pulse, streams and host pins arrive
  asynchronously; block programming and offsets come from core logic.
*/
`timescale 1ns/1ps
`default_nettype none
`include "tsw_consts.vh"

// How it works
// - eight serial streams in, eight out
// - any output channel reads any input channel
// - shift on edges of external serial clock
// - frame pulse polarity found from idle level
// - reset clears state, tristates all outputs
// - non-muxed mode addresses from address lines
// - muxed strobe style: strobe high with select
// - non-muxed strobe style: strobe low with select
// - read strobe low drives host data bus
// - direction input sets data bus direction
// - write strobe low takes low data byte
// - strobes except address latch ignored while chip select high
// - per-channel output high impedance
// - per-channel variable or constant delay
// - per-stream input frame offset
// - frame evaluation input offset measured
// - per-channel processor mode byte output
// - block program writes whole connection memory
// - style select high muxed, low non-muxed
// - address latch strobe used only when muxed
// - acknowledge low, then high, then released
// - frames of 32 eight-bit channels
module tsw_top (
  input  wire        i_core_clk,
  input  wire        i_resetn,
  input  wire        i_core_ce,
  input  wire        i_sclk,
  input  wire        i_frame_sync_in,
  input  wire        i_frame_eval_in,
  input  wire [7:0]  i_serial_in_streams,
  output reg  [7:0]  o_serial_out_streams,
  output reg  [7:0]  o_tx_oe_n,
  input  wire [31:0] i_stream_offset,
  output reg  [7:0]  o_fe_offset,
  output reg         o_fe_valid,
  output reg         o_frame_pol,
  input  wire        i_block_start,
  input  wire [10:0] i_block_word,
  output reg         o_block_busy,
  input  wire        i_host_port_style_sel,
  input  wire        i_rdwr_style,
  input  wire        i_cs_n,
  input  wire        i_data_strobe_or_read,
  input  wire        i_rw_or_wr,
  input  wire        i_addr_latch_strobe,
  input  wire [7:0]  i_host_addr_lines,
  input  wire [7:0]  i_muxed_addr_data_low,
  input  wire [7:0]  i_data_high_byte,
  output reg  [7:0]  o_muxed_addr_data_low,
  output reg  [7:0]  o_data_high_byte,
  output reg         o_host_data_oe_n,
  output reg         o_transfer_ack_n,
  output reg         o_transfer_ack_oe_n
);

  // host access states, one-hot
  localparam [2:0] ST_IDLE = 3'b001;
  localparam [2:0] ST_ACK  = 3'b010;
  localparam [2:0] ST_REL  = 3'b100;

  // bit position of a stream after its frame offset
  function [7:0] tsw_scnt;
    input [7:0] bitc;
    input [3:0] off;
    begin
      tsw_scnt = bitc - {4'h0, off};
    end
  endfunction

  reg  [`TSW_SYNC_W-1:0] sy1_r;            // first stage, read only by sy2_r
  reg  [`TSW_SYNC_W-1:0] sy2_r;            // synchronised pins
  // synced pins: port style, strobes, address, data, serial side
  wire                   muxm, rdwr, cs_n, dsrd, rwwr, ale, sclk, fsy, fev;
  wire [7:0]             haddr, adin, dhin, rxs;
  reg                    sclk_d_r, fsy_d_r, fev_d_r; // last levels seen
  reg  [2:0]             run_r;            // frame pulse steady count
  reg                    act_d_r;          // frame pulse active last
  reg  [8:0]             cnt_r;            // serial clocks into frame
  reg                    bank_r;           // data memory bank written
  reg  [7:0]             dm_r [0:511];     // two frames of input bytes
  reg  [7:0]             ish_r [0:7];      // input shifters
  reg  [`TSW_CM_W-1:0]   cm_r [0:255];     // connection memory
  reg  [7:0]             osh_r [0:7];      // output shifters
  reg  [7:0]             pf_r [0:7];       // prefetched next byte
  reg  [7:0]             pfz_r, lhz;       // hiz per stream: prefetched, looked up
  reg  [7:0]             lk [0:7], sc [0:7]; // next-channel byte, bit counts
  reg  [`TSW_CM_W-1:0]   ent;
  reg                    rb, ale_d_r;      // bank read, latch strobe last
  reg  [2:0]             st_r;             // host state
  reg  [7:0]             alat_r;           // latched muxed address
  reg  [7:0]             bidx_r;           // block program index
  reg  [`TSW_CM_W-1:0]   bword_r;          // block program word
  integer                i;

  wire tick = sclk & ~sclk_d_r;            // serial clock rise
  wire smp  = tick & cnt_r[0];             // mid-bit sample
  wire otk  = tick & ~cnt_r[0];            // bit launch
  wire fact = ~(fsy ^ o_frame_pol);        // frame pulse active level
  wire fst  = tick & fact & ~act_d_r;      // frame start
  wire [4:0] nch = cnt_r[8:4] + 5'h01;     // next channel, wraps at 32
  // strobe qualification depends on port style
  wire hact = ~cs_n & (rdwr ? (~dsrd | ~rwwr) :
              (muxm ? dsrd : ~dsrd));
  wire hrd  = rdwr ? ~dsrd : rwwr;
  wire [7:0] hadr = muxm ? alat_r : haddr;

  assign {muxm, rdwr, cs_n, dsrd, rwwr, ale, haddr, adin, dhin,
          sclk, fsy, fev, rxs} = sy2_r;

  // two flip-flops on every pin before logic sees it
  always @(posedge i_core_clk or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      sy1_r <= {`TSW_SYNC_W{1'b0}};
      sy2_r <= {`TSW_SYNC_W{1'b0}};
    end
    else if (i_core_ce)
    begin
      sy1_r <= {i_host_port_style_sel, i_rdwr_style, i_cs_n,
                i_data_strobe_or_read, i_rw_or_wr, i_addr_latch_strobe,
                i_host_addr_lines, i_muxed_addr_data_low,
                i_data_high_byte, i_sclk, i_frame_sync_in,
                i_frame_eval_in, i_serial_in_streams};
      sy2_r <= sy1_r;
    end
  end

  // frame timing: polarity, frame counter, evaluation measurement
  always @(posedge i_core_clk or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      sclk_d_r    <= 1'b0;
      fsy_d_r     <= 1'b0;
      run_r       <= 3'h0;
      act_d_r     <= 1'b0;
      cnt_r       <= 9'h000;
      bank_r      <= 1'b0;
      fev_d_r     <= 1'b0;
      o_frame_pol <= 1'b0;
      o_fe_offset <= 8'h00;
      o_fe_valid  <= 1'b0;
    end
    else if (i_core_ce)
    begin
      sclk_d_r <= sclk;
      fev_d_r  <= fev;
      if (tick)
      begin
        fsy_d_r <= fsy;
        act_d_r <= fact;
        // a long steady level is idle; the pulse is the other level
        if (fsy != fsy_d_r)
          run_r <= 3'h0;
        else if (run_r != `TSW_IDLE_RUN)
          run_r <= run_r + 3'h1;
        else
          o_frame_pol <= ~fsy;
        if (fst)
        begin
          cnt_r  <= 9'h000;
          bank_r <= ~bank_r;
        end
        else
          cnt_r <= cnt_r + 9'h001;
      end
      // offset in bit periods from frame start to falling evaluation
      if (fev_d_r & ~fev)
      begin
        o_fe_offset <= cnt_r[8:1];
        o_fe_valid  <= 1'b1;
      end
    end
  end

  // per-stream offset bit counts and next-channel lookup
  always @*
  begin
    ent = `TSW_CM_RST;
    rb  = 1'b0;
    for (i = 0; i < 8; i = i + 1)
    begin
      sc[i] = tsw_scnt(cnt_r[8:1], i_stream_offset[i*4 +: 4]);
      ent   = cm_r[{i[2:0], nch}];
      // constant delay always reads last frame; variable takes the
      // newest copy, this frame if the source slot has gone by
      if (ent[`TSW_CM_CDLY])
        rb = ~bank_r;
      else if (ent[4:0] < nch)
        rb = bank_r;
      else
        rb = ~bank_r;
      if (ent[`TSW_CM_PROC])
        lk[i] = ent[7:0];
      else
        lk[i] = dm_r[{rb, ent[`TSW_CM_SRC_MSB:0]}];
      lhz[i] = ent[`TSW_CM_HIZ];
    end
  end

  // serial input capture into the data memory
  always @(posedge i_core_clk or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      for (i = 0; i < 512; i = i + 1)
        dm_r[i] <= `TSW_DM_RST;
      for (i = 0; i < 8; i = i + 1)
        ish_r[i] <= 8'h00;
    end
    else if (i_core_ce && smp)
    begin
      for (i = 0; i < 8; i = i + 1)
      begin
        ish_r[i] <= {ish_r[i][6:0], rxs[i]};
        if (sc[i][2:0] == `TSW_LAST_BIT)
          dm_r[{bank_r, i[2:0], sc[i][7:3]}] <= {ish_r[i][6:0], rxs[i]};
      end
    end
  end

  // serial output: byte fetched one slot early, loaded at slot start
  always @(posedge i_core_clk or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      o_serial_out_streams <= 8'h00;
      o_tx_oe_n            <= 8'hff;
      pfz_r                <= 8'hff;
      for (i = 0; i < 8; i = i + 1)
      begin
        osh_r[i] <= 8'h00;
        pf_r[i]  <= 8'h00;
      end
    end
    else if (i_core_ce && otk)
    begin
      for (i = 0; i < 8; i = i + 1)
      begin
        if (cnt_r[3:1] == 3'h0)
        begin
          o_serial_out_streams[i] <= pf_r[i][7];
          osh_r[i]                <= {pf_r[i][6:0], 1'b0};
          o_tx_oe_n[i]            <= pfz_r[i];
          pf_r[i]                 <= lk[i];
          pfz_r[i]                <= lhz[i];
        end
        else
        begin
          o_serial_out_streams[i] <= osh_r[i][7];
          osh_r[i]                <= {osh_r[i][6:0], 1'b0};
        end
      end
    end
  end

  // host port and block programming share the connection memory
  always @(posedge i_core_clk or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      for (i = 0; i < 256; i = i + 1)
        cm_r[i] <= `TSW_CM_RST;
      st_r                  <= ST_IDLE;
      ale_d_r               <= 1'b0;
      alat_r                <= 8'h00;
      bidx_r                <= 8'h00;
      bword_r               <= `TSW_CM_RST;
      o_block_busy          <= 1'b0;
      o_muxed_addr_data_low <= 8'h00;
      o_data_high_byte      <= 8'h00;
      o_host_data_oe_n      <= 1'b1;
      o_transfer_ack_n      <= 1'b1;
      o_transfer_ack_oe_n   <= 1'b1;
    end
    else if (i_core_ce)
    begin
      ale_d_r <= ale;
      // strobe is ignored outside muxed mode, so a grounded pin is safe
      if (muxm & ale_d_r & ~ale)
        alat_r <= adin;
      // block fill runs one word per cycle; host waits meanwhile
      if (o_block_busy)
      begin
        cm_r[bidx_r] <= bword_r;
        bidx_r       <= bidx_r + 8'h01;
        if (bidx_r == 8'hff)
          o_block_busy <= 1'b0;
      end
      else if (i_block_start && (st_r == ST_IDLE))
      begin
        o_block_busy <= 1'b1;
        bidx_r       <= 8'h00;
        bword_r      <= i_block_word;
      end
      case (st_r)
        ST_IDLE:
        begin
          if (hact && !o_block_busy && !i_block_start)
          begin
            if (hrd)
            begin
              o_muxed_addr_data_low <= cm_r[hadr][7:0];
              o_data_high_byte      <= {5'h00, cm_r[hadr][10:8]};
              o_host_data_oe_n      <= 1'b0;
            end
            else
              cm_r[hadr] <= {dhin[2:0], adin};
            o_transfer_ack_n    <= 1'b0;
            o_transfer_ack_oe_n <= 1'b0;
            st_r                <= ST_ACK;
          end
        end
        ST_ACK:
        begin
          // hold the bus and ack until the strobe goes away
          if (!hact)
          begin
            o_transfer_ack_n <= 1'b1;
            o_host_data_oe_n <= 1'b1;
            st_r             <= ST_REL;
          end
        end
        ST_REL:
        begin
          o_transfer_ack_oe_n <= 1'b1;
          st_r                <= ST_IDLE;
        end
        default:
          st_r <= ST_IDLE;
      endcase
    end
  end

endmodule // tsw_top
`default_nettype wire

/* File: hw/tsw_consts.vh */
/*
  constants for the time-slot switch front end: connection word layout,
  sync vector width and frame polarity detection run length.
  assumes inclusion by bare name from tsw_top.v.
*/
`ifndef TSW_CONSTS_VH
`define TSW_CONSTS_VH
// connection word: source address or processor byte in [7:0]
`define TSW_CM_SRC_MSB 7
`define TSW_CM_PROC    8
`define TSW_CM_CDLY    9
`define TSW_CM_HIZ     10
`define TSW_CM_W       11
// reset values
`define TSW_CM_RST     11'h000
`define TSW_DM_RST     8'h00
// widths of the pin synchroniser vector
`define TSW_SYNC_W     41
// frame pulse level must hold this many serial clocks after its change, and one more, to count as idle
`define TSW_IDLE_RUN   3'h4
// last bit of a byte within a channel
`define TSW_LAST_BIT   3'h7
// shortest reset pulse from outside, ns, and in core cycles (10 ns)
`define TSW_RST_MIN_NS 100
`define TSW_RST_MIN_CYC ((`TSW_RST_MIN_NS + 9) / 10)
`endif

/* File: verif/tsw_assertions.sv */
/* port checker for tsw_top: reset state, ack sequencing, select gating, block fill.
   assumes one core clock domain and async active-low reset. */
`timescale 1ns/1ps
`default_nettype none
module tsw_assertions (
  input wire logic       i_core_clk,
  input wire logic       i_resetn,
  input wire logic       i_cs_n,
  input wire logic       i_block_start,
  input wire logic [7:0] o_tx_oe_n,
  input wire logic       o_host_data_oe_n,
  input wire logic       o_transfer_ack_n,
  input wire logic       o_transfer_ack_oe_n,
  input wire logic       o_block_busy,
  input wire logic       o_fe_valid
);
  logic [8:0] fill_cnt_r; // cycles of the running fill
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (!i_resetn);
  // counts busy cycles, cleared when idle
  always @(posedge i_core_clk or negedge i_resetn)
    if (!i_resetn)
      fill_cnt_r <= 9'h000;
    else
      fill_cnt_r <= o_block_busy ? fill_cnt_r + 9'h001 : 9'h000;
  // ack pin held one cycle after the high drive, then let go
  sequence ack_rel_s;
    !o_transfer_ack_oe_n ##1 o_transfer_ack_oe_n;
  endsequence
  // select high long enough to clear the synchroniser
  sequence cs_idle_s;
    i_cs_n [*4];
  endsequence
  chk_reset_hiz: assert property (disable iff (1'b0)
    !i_resetn |-> o_tx_oe_n == 8'hff && o_host_data_oe_n && o_transfer_ack_oe_n)
    else $error("outputs driven in reset");
  chk_ack_release: assert property ($rose(o_transfer_ack_n) |-> ack_rel_s)
    else $error("ack pin not released after high drive");
  chk_ack_driven: assert property (!o_transfer_ack_n |-> !o_transfer_ack_oe_n)
    else $error("ack low while pin released");
  chk_read_drive: assert property (!o_host_data_oe_n |-> !o_transfer_ack_n)
    else $error("data bus driven outside an access");
  chk_cs_ignored: assert property (
    cs_idle_s ##0 o_transfer_ack_oe_n |=> o_transfer_ack_oe_n)
    else $error("access answered without select");
  chk_fill_len: assert property ($fell(o_block_busy) |-> fill_cnt_r == 9'h100)
    else $error("fill not 256 cycles");
  chk_fill_start: assert property (
    i_block_start && !o_block_busy && o_transfer_ack_oe_n |=> o_block_busy)
    else $error("fill did not start");
  chk_fill_holds: assert property (
    o_block_busy && o_transfer_ack_oe_n |=> o_transfer_ack_oe_n)
    else $error("access answered during fill");
  chk_fe_sticky: assert property (o_fe_valid |=> o_fe_valid)
    else $error("measure valid dropped");
endmodule // tsw_assertions
bind tsw_top tsw_assertions u_chk (.*);
`default_nettype wire

/* File: verif/tsw_far_end.sv */
/* far side: free serial clock, frame pulse, serial bits, eval pulse.
   assumes the bench picks the pulse polarity. */
`timescale 1ns/1ps
`default_nettype none
module tsw_far_end (
  input  wire logic       i_pol_high,
  output var  logic       o_sclk,
  output var  logic       o_fsync,
  output var  logic       o_fe,
  output var  logic [7:0] o_rx
);
  int         seed = 34027; // fixed, repeatable bits
  logic [8:0] cnt_r = 0;    // clock count in frame
  initial
  begin
    o_sclk = 0;
    o_fsync = 1;
    o_fe = 0;
    o_rx = 0;
  end
  always #122 o_sclk = ~o_sclk; // free running
  // change on the fall so the rise samples settled levels
  always @(negedge o_sclk)
  begin
    cnt_r <= cnt_r + 9'h001; // 512 clocks a frame
    o_fsync <= (cnt_r == 9'h1ff) ? i_pol_high : !i_pol_high;
    o_fe <= cnt_r < 9'h040;
    if (cnt_r[0])
      o_rx <= 8'($random(seed)); // two clocks a bit
  end
endmodule // tsw_far_end
`default_nettype wire

/* File: verif/tb_top.sv */
/* bench: host accesses in three port styles, select gating, fill, polarity.
   assumes tsw_far_end on the serial side and the bound checker. */
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, s) begin n_tests++; if ((s) !== (e)) begin err_count++; \
  $display("wrong value %s expected %h seen %h", n, e, s); end end
module tb_top;
  logic i_core_clk = 0, i_resetn = 1, i_core_ce = 1, i_block_start = 0, i_cs_n = 1;
  logic i_host_port_style_sel = 0, i_rdwr_style = 0, i_data_strobe_or_read = 1;
  logic [8:0] c;
  logic [7:0] b;
  logic [2:0] s;
  logic i_rw_or_wr = 1, i_addr_latch_strobe = 0, pol_high = 1;
  logic [10:0] i_block_word = 0, q, w;
  logic [7:0]  i_host_addr_lines = 0, i_muxed_addr_data_low = 0, i_data_high_byte = 0, a;
  logic [31:0] i_stream_offset = 0;
  wire i_sclk, i_frame_sync_in, i_frame_eval_in, o_fe_valid, o_frame_pol, o_block_busy;
  wire o_host_data_oe_n, o_transfer_ack_n, o_transfer_ack_oe_n;
  wire [7:0] i_serial_in_streams, o_serial_out_streams, o_tx_oe_n, o_fe_offset;
  wire [7:0] o_muxed_addr_data_low, o_data_high_byte;
  int err_count = 0, n_tests = 0, seed = 34027, k;
  tsw_top dut (.*);
  tsw_far_end far (.i_pol_high(pol_high), .o_sclk(i_sclk), .o_fsync(i_frame_sync_in),
    .o_fe(i_frame_eval_in), .o_rx(i_serial_in_streams));
  always #5 i_core_clk = ~i_core_clk;
  task stop_test;
    $display("checks %0d mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  // one access; m 0 non-muxed, 1 muxed strobe, 2 muxed read/write strobes
  task acc(input int m, input logic [7:0] ad, input logic wr, input logic [10:0] d);
    @(negedge i_core_clk);
    i_host_port_style_sel = (m != 0);
    i_rdwr_style = (m == 2);
    i_host_addr_lines = ad;
    i_data_high_byte = {5'h00, d[10:8]};
    i_muxed_addr_data_low = (m != 0) ? ad : d[7:0];
    i_rw_or_wr = (m == 2) | !wr;
    i_data_strobe_or_read = (m != 1);
    if (m != 0)
    begin
      i_addr_latch_strobe = 1;
      repeat (4) @(negedge i_core_clk);
      i_addr_latch_strobe = 0; // address taken on the fall
      repeat (4) @(negedge i_core_clk);
      i_muxed_addr_data_low = d[7:0];
    end
    repeat (2) @(negedge i_core_clk);
    i_cs_n = 0;
    if (m == 2 && wr)
      i_rw_or_wr = 0;
    else
      i_data_strobe_or_read = (m == 1);
    for (k = 0; k < 600 && o_transfer_ack_n !== 1'b0; k++)
      @(negedge i_core_clk);
    q = {o_data_high_byte[2:0], o_muxed_addr_data_low};
    `CHK("data drive", !wr, o_host_data_oe_n === 1'b0)
    i_cs_n = 1;
    i_data_strobe_or_read = (m != 1);
    i_rw_or_wr = 1;
    for (k = 0; k < 20 && o_transfer_ack_oe_n !== 1'b1; k++)
      @(negedge i_core_clk);
  endtask
  initial
  begin
    #1 i_resetn = 0;
    repeat (16) @(negedge i_core_clk); // well over the minimum pulse
    `CHK("tx enables", 8'hff, o_tx_oe_n)
    `CHK("ack enable", 1'b1, o_transfer_ack_oe_n)
    i_resetn = 1;
    i_stream_offset = $random(seed);
    acc(0, 8'h00, 0, 0);
    `CHK("reset word", 11'h000, q)
    for (int i = 0; i < 9; i++)
    begin
      a = (i == 0) ? 8'hff : 8'($random(seed));
      w = (i == 1) ? 11'h7ff : 11'($random(seed));
      acc(i % 3, a, 1, w);
      acc((i + 1) % 3, a, 0, 0);
      `CHK("readback", w, q)
    end
    @(negedge i_core_clk);
    i_host_port_style_sel = 0;
    i_muxed_addr_data_low = ~w[7:0];
    i_rw_or_wr = 0;
    i_data_strobe_or_read = 0;
    repeat (20) @(negedge i_core_clk);
    `CHK("unselected ack", 1'b1, o_transfer_ack_oe_n)
    i_data_strobe_or_read = 1;
    i_rw_or_wr = 1;
    acc(0, a, 0, 0);
    `CHK("unselected write", w, q)
    i_block_word = 11'($random(seed));
    i_block_start = 1;
    @(negedge i_core_clk);
    i_block_start = 0;
    `CHK("fill busy", 1'b1, o_block_busy)
    acc(2, ~a, 0, 0);
    `CHK("fill word", i_block_word, q)
    // one output channel in processor mode, driven, carrying byte b
    s = 3'($random(seed));
    b = 8'($random(seed));
    a = {s, 5'($random(seed))};
    acc(1, a, 1, {3'h1, b});
    repeat (30000) @(negedge i_core_clk);
    `CHK("polarity", 1'b1, o_frame_pol)
    `CHK("measure valid", 1'b1, o_fe_valid)
    // evaluation pin falls 64 serial clocks into the frame: 32 bit periods
    `CHK("fe offset", 8'h20, o_fe_offset)
    // bit j of slot k launches after count 16k+2j, read one clock later
    for (int j = 0; j < 8; j++)
    begin
      c = 9'({a[4:0], 4'h0} + 2 * j + 2);
      @(negedge i_sclk iff far.cnt_r == c);
      `CHK("serial bit", b[7 - j], o_serial_out_streams[s])
      `CHK("serial enable", 1'b0, o_tx_oe_n[s])
    end
    pol_high = 0;
    repeat (30000) @(negedge i_core_clk);
    `CHK("polarity", 1'b0, o_frame_pol)
    stop_test;
  end
  // cuts a hang short
  initial
  begin
    #900000;
    err_count++;
    stop_test;
  end
endmodule // tb_top
`default_nettype wire
